// [hw/psi_top.sv]
`timescale 1ns/1ps
`default_nettype none
module psi_top
  import psi_pkg::*;
#(
  parameter logic [CNT_W-1:0] HALF_CYC = BLINK_HALF_CYC,
  parameter logic [CNT_W-1:0] STR_CYC = STRETCH_CYC
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic suspend_hold,
  input wire logic indicator_style_strap,
  input wire logic [NIND-1:0] indicator_polarity_strap,
  input wire logic [NPORT-1:0] link_up,
  input wire logic [2*NPORT-1:0] link_speed,
  input wire logic [NPORT-1:0] full_duplex,
  input wire logic [NPORT-1:0] activity,
  input wire logic [NPORT-1:0] collision,
  input wire logic [NPORT-1:0] pd_fault,
  output logic [NIND-1:0] led_pin_out,
  output logic [NIND-1:0] led_pin_oe
);
  typedef struct packed {
    logic [2:0] susp_sync;
    logic susp;
    logic [NIND:0] strap_s1;
    logic [NIND:0] strap_s2;
    logic [NIND:0] strap_s3;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic style;
    logic [NPORT-1:0] legacy;
    logic [NPORT-1:0][7:0] sel;
    logic [NPORT-1:0] port_isolate_bit;
    logic [NPORT-1:0] pd;
    logic [NPORT-1:0][7:0] pincfg;
    logic stretch_en;
    logic blink_fast;
    logic [NIND-1:0] pol;
    logic [NIND-1:0] lit;
    logic [NIND-1:0] pin_out;
    logic [NIND-1:0] pin_oe;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rdy;
    logic hresp;
    logic [31:0] rdata;
  } psi_state_t;

  psi_state_t st;
  psi_state_t nxt;
  logic phase;
  logic [NPORT-1:0] act_s;
  logic [NPORT-1:0] col_s;
  logic take;
  logic [NIND-1:0] force8;

  // Per-port register window below the common block
  function automatic logic is_port_reg(input logic [31:0] a);
    return (a[31:8] == 24'h000000) && (a[7:6] == 2'h0) && (a[1:0] == 2'h0);
  endfunction

  // Register read mux; unmapped locations read zero
  function automatic logic [31:0] read_val(input psi_state_t s, input logic [31:0] a);
    logic [1:0] p;
    p = a[5:4];
    read_val = 32'h00000000;
    if (is_port_reg(a))
    begin
      unique case (a[3:0])
        OFS_CTRL1[3:0]: read_val[LEGACY_BIT] = s.legacy[p];
        OFS_CTRL2[3:0]: read_val[7:0] = s.sel[p];
        OFS_BASIC[3:0]:
        begin
          read_val[ISO_BIT] = s.port_isolate_bit[p];
          read_val[PD_BIT] = s.pd[p];
        end
        OFS_PINCFG[3:0]: read_val[7:0] = s.pincfg[p];
        default: read_val = 32'h00000000;
      endcase
    end
    else if (a == {24'h000000, OFS_BEHAV})
    begin
      read_val[STRETCH_BIT] = s.stretch_en;
      read_val[FAST_BIT] = s.blink_fast;
    end
    else if (a == {24'h000000, OFS_POL})
      read_val[7:0] = s.pol;
    else if (a == {24'h000000, OFS_STATUS})
    begin
      read_val[7:0] = s.lit;
      read_val[ST_SUSP_BIT] = s.susp;
      read_val[ST_STYLE_BIT] = s.style;
      read_val[ST_DONE_BIT] = s.strap_done;
    end
  endfunction

  // Mask of link speeds matched by enhanced codes 0 to 6, order {1000,100,10}
  function automatic logic [2:0] spd_mask(input logic [3:0] code);
    unique case (code)
      4'h0: return 3'h7;
      4'h1: return 3'h4;
      4'h2: return 3'h2;
      4'h3: return 3'h1;
      4'h4: return 3'h6;
      4'h5: return 3'h5;
      4'h6: return 3'h3;
      default: return 3'h0;
    endcase
  endfunction

  // One indicator's wanted state, returned as {on, blink}
  function automatic logic [1:0] eval_ind(input logic legacy, input logic style,
                                          input logic two, input logic [3:0] code,
                                          input logic link, input logic [1:0] spd,
                                          input logic fdx, input logic act,
                                          input logic col, input logic flt);
    logic [2:0] sp;
    logic used;
    sp = {spd == SPD_1000, spd == SPD_100, spd == SPD_10};
    used = 1'b0;
    eval_ind = 2'h0;
    if (legacy && style)
    begin
      if (two)
        eval_ind = {link, 1'b0}; // see R5
      else
        eval_ind = {1'b0, link & act}; // see R5
    end
    else if (legacy)
    begin
      used = link & (two ? (sp[2] | sp[0]) : (sp[1] | sp[0])); // see R6
      eval_ind = {used, used & act}; // see R7
    end
    else if (code <= 4'h6)
    begin
      used = link & (|(sp & spd_mask(code))); // see R8
      eval_ind = {used, used & act};
    end
    else
    begin
      unique case (code)
        CODE_DUPLEX: eval_ind = {link & fdx, link & !fdx & col}; // see R9
        CODE_COLL: eval_ind = {1'b0, col}; // see R10
        CODE_ACT: eval_ind = {1'b0, act}; // see R10
        CODE_FAULT: eval_ind = {flt, 1'b0}; // see R11
        CODE_ON: eval_ind = 2'h2; // see R12
        default: eval_ind = 2'h0; // see R11 R12
      endcase
    end
  endfunction

  // Activity stretch and blink timing
  psi_blink #(
    .HALF_CYC(HALF_CYC),
    .STR_CYC(STR_CYC)
  ) u_blink (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .fast(st.blink_fast),
    .stretch_en(st.stretch_en),
    .act(activity),
    .col(collision),
    .phase(phase),
    .act_s(act_s),
    .col_s(col_s)
  );

  assign take = hsel & htrans[1] & hready;

  // Reset image of the state: legacy mode, individual style, stretch on, bus ready
  localparam psi_state_t rst_val_c = '{rdy: 1'b1, legacy: {NPORT{LEGACY_RST}},
    sel: {NPORT{SEL_RST}}, pincfg: {NPORT{PINCFG_RST}}, pol: POL_RST,
    stretch_en: STRETCH_RST, style: 1'b1, default: '0};

  // Force-off mask per indicator
  always_comb
  begin
    for (int i = 0; i < NIND; i++)
      force8[i] = st.port_isolate_bit[i/2] | st.pd[i/2] | st.susp; // see R14 R15
  end

  // Next-state logic: pin sync, strap capture, bus, indicators
  always_comb
  begin
    nxt = st;
    nxt.susp_sync = {st.susp_sync[1:0], suspend_hold};
    if (st.susp_sync[1] == st.susp_sync[2])
      nxt.susp = st.susp_sync[2]; // see R15
    nxt.strap_s1 = {indicator_style_strap, indicator_polarity_strap};
    nxt.strap_s2 = st.strap_s1;
    nxt.strap_s3 = st.strap_s2;
    if (!st.strap_done)
    begin
      if (st.strap_cnt != STRAP_WAIT)
        nxt.strap_cnt = st.strap_cnt + 2'h1;
      else if (st.strap_s2 == st.strap_s3)
      begin
        nxt.strap_done = 1'b1;
        nxt.style = st.strap_s3[NIND]; // see R2 R3
        nxt.pol = ~st.strap_s3[NIND-1:0]; // see R18
      end
    end
    // Write data phase lands one cycle after its address phase
    nxt.wr_pend = 1'b0;
    if (st.wr_pend)
    begin
      if (is_port_reg({24'h000000, st.wr_addr}))
      begin
        unique case (st.wr_addr[3:0])
          OFS_CTRL1[3:0]: nxt.legacy[st.wr_addr[5:4]] = hwdata[LEGACY_BIT]; // see R3 R4
          OFS_CTRL2[3:0]: nxt.sel[st.wr_addr[5:4]] = hwdata[7:0]; // see R4
          OFS_BASIC[3:0]:
          begin
            nxt.port_isolate_bit[st.wr_addr[5:4]] = hwdata[ISO_BIT];
            nxt.pd[st.wr_addr[5:4]] = hwdata[PD_BIT];
          end
          OFS_PINCFG[3:0]: nxt.pincfg[st.wr_addr[5:4]] = hwdata[7:0];
          default: nxt.wr_pend = 1'b0;
        endcase
      end
      else if (st.wr_addr == OFS_BEHAV)
      begin
        nxt.stretch_en = hwdata[STRETCH_BIT]; // see R13
        nxt.blink_fast = hwdata[FAST_BIT];
      end
      else if (st.wr_addr == OFS_POL)
        nxt.pol = hwdata[7:0];
    end
    if (take && hwrite)
    begin
      nxt.wr_pend = (haddr[31:8] == 24'h000000);
      nxt.wr_addr = haddr[7:0];
    end
    if (take && !hwrite)
      nxt.rdata = read_val(nxt, haddr);
    nxt.hresp = 1'b0;
    nxt.rdy = 1'b1;
    // Indicator state and pin drive
    for (int i = 0; i < NIND; i++)
    begin
      logic [1:0] ob;
      ob = eval_ind(st.legacy[i/2], st.style, i[0], st.sel[i/2][i[0]*4 +: 4],
                    link_up[i/2], link_speed[(i/2)*2 +: 2], full_duplex[i/2],
                    act_s[i/2], col_s[i/2], pd_fault[i/2]);
      nxt.lit[i] = !force8[i] & (ob[0] ? phase : ob[1]); // see R7 R14 R19
    end
    for (int g = 0; g < NIND; g++)
    begin
      logic [3:0] cfg;
      logic en;
      logic lv;
      cfg = nxt.pincfg[IND_OF_PIN[g]/2][(IND_OF_PIN[g]%2)*4 +: 4];
      en = cfg[PC_EN] & cfg[PC_ALT] & cfg[PC_OUT]; // see R1 R16
      lv = nxt.lit[IND_OF_PIN[g]];
      if (!en)
      begin
        nxt.pin_out[g] = 1'b0;
        nxt.pin_oe[g] = 1'b0;
      end
      else if (cfg[PC_OD])
      begin
        nxt.pin_out[g] = nxt.pol[IND_OF_PIN[g]]; // see R17
        nxt.pin_oe[g] = lv;
      end
      else
      begin
        nxt.pin_out[g] = nxt.pol[IND_OF_PIN[g]] ~^ lv; // see R18
        nxt.pin_oe[g] = 1'b1;
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= rst_val_c;
    else if (clk_en)
      st <= nxt;
  end

  assign hreadyout = st.rdy;
  assign hresp = st.hresp;
  assign hrdata = st.rdata;
  assign led_pin_out = st.pin_out;
  assign led_pin_oe = st.pin_oe;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_force_off: assert property (clk_en && (|force8) |=> (st.lit & $past(force8)) == 8'h00) // see R14
    else $error("forced indicator still lit");
  chk_susp_dark: assert property (clk_en && st.susp |=> st.lit == 8'h00) // see R15
    else $error("indicator lit during suspend-hold");
  chk_code_on: assert property (clk_en && !st.legacy[0] && st.sel[0][3:0] == CODE_ON // see R12
    && !force8[0] |=> st.lit[0])
    else $error("code 15 indicator not lit");
  chk_code_off: assert property (clk_en && !st.legacy[0] && st.sel[0][3:0] == CODE_OFF // see R12
    |=> !st.lit[0])
    else $error("code 14 indicator lit");
  chk_indiv_link: assert property (clk_en && st.legacy[1] && st.style && link_up[1] // see R5
    && !force8[3] |=> st.lit[3])
    else $error("individual mode link indicator dark");
  chk_tri_gig: assert property (clk_en && st.legacy[0] && !st.style && link_up[0] // see R6
    && link_speed[1:0] == SPD_1000 |=> !st.lit[0])
    else $error("tri-colour indicator one lit at 1000");
  chk_od_release: assert property (st.pin_oe[1] && st.pincfg[0][4+PC_OD] // see R17
    |-> st.lit[1] && st.pin_out[1] == st.pol[1])
    else $error("open-drain pin driven while dark");
  chk_pp_level: assert property (st.pincfg[0][3:0] == 4'h7 // see R18
    |-> st.pin_oe[0] && st.pin_out[0] == (st.pol[0] ~^ st.lit[0]))
    else $error("push-pull level wrong for polarity");
  chk_strap_pol: assert property ($rose(st.strap_done) && !$past(st.wr_pend)
    |-> st.pol == ~$past(st.strap_s3[7:0])) // see R18
    else $error("polarity not inverse of strap");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answered with wait or error");

  cov_tri_blink: cover property (st.legacy[0] && !st.style && st.lit[0] ##1 !st.lit[0]);
  cov_duplex_blink: cover property (!st.legacy[1] && st.sel[1][3:0] == CODE_DUPLEX
    && collision[1]);
  cov_susp_rise: cover property ($rose(st.susp));
endmodule // psi_top
`default_nettype wire

// [hw/psi_pkg.sv]
// Contract
// R1: Eight indicator outputs, two per port, on GPIO11/12, 13/14, 17/18, 19/20.
// R2: One style strap gives all indicators the same default; port registers override.
// R3: Legacy bit set: strap high selects individual mode, strap low tri-colour.
// R4: Legacy bit clear: enhanced mode, each indicator shows its own selected code.
// R5: Individual: indicator two shows link, indicator one blinks on activity.
// R6: Tri-colour: 1000 on two, 100 on one, 10 on both, none off.
// R7: Tri-colour: lit indicators steady when idle, blinking with activity.
// R8: Codes 0 to 6 show link and activity for their speed sets.
// R9: Code 8 steady for full duplex, blinks on half duplex collisions.
// R10: Code 9 blinks on collisions, code 10 blinks on activity, never steady.
// R11: Code 12 steady on parallel detect fault; 7, 11, 13 reserved.
// R12: Code 14 forces off, code 15 forces on.
// R13: Blink and pulse stretch are set in a separate behaviour register.
// R14: Isolate, power-down or suspend-hold force all port indicators off.
// R15: Suspend-hold high disables indicators until the pin is low again.
// R16: Software enables the pin as GPIO, alternate, output, and picks drive type.
// R17: Open-drain choice becomes open-source or open-drain by active polarity.
// R18: Default active polarity is the inverse of the sampled polarity strap.
// R19: Blinking toggles at a fixed clock-derived rate while stretched activity lasts.
package psi_pkg;
  localparam int NPORT = 4;
  localparam int NIND = 8;
  localparam int CNT_W = 24;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int BLINK_HALF_MS = 100;
  localparam int STRETCH_MS = 40;
  localparam logic [CNT_W-1:0] BLINK_HALF_CYC = CNT_W'(BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STRETCH_CYC = CNT_W'(STRETCH_MS * 1000000 / CLK_PERIOD_NS);
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_BASIC = 8'h08;
  localparam logic [7:0] OFS_PINCFG = 8'h0C;
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [7:0] OFS_BEHAV = 8'h40;
  localparam logic [7:0] OFS_POL = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  // Field positions
  localparam int LEGACY_BIT = 6;
  localparam int SEL1_LSB = 0;
  localparam int SEL2_LSB = 4;
  localparam int ISO_BIT = 10;
  localparam int PD_BIT = 11;
  localparam int PC_EN = 0;
  localparam int PC_ALT = 1;
  localparam int PC_OUT = 2;
  localparam int PC_OD = 3;
  localparam int STRETCH_BIT = 0;
  localparam int FAST_BIT = 1;
  localparam int ST_SUSP_BIT = 8;
  localparam int ST_STYLE_BIT = 9;
  localparam int ST_DONE_BIT = 10;
  // Reset values
  localparam logic LEGACY_RST = 1'b1;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] PINCFG_RST = 8'h00;
  localparam logic [7:0] POL_RST = 8'hFF;
  localparam logic STRETCH_RST = 1'b1;
  // Link speed encoding
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // Enhanced codes with special meaning
  localparam logic [3:0] CODE_DUPLEX = 4'h8;
  localparam logic [3:0] CODE_COLL = 4'h9;
  localparam logic [3:0] CODE_ACT = 4'hA;
  localparam logic [3:0] CODE_FAULT = 4'hC;
  localparam logic [3:0] CODE_OFF = 4'hE;
  localparam logic [3:0] CODE_ON = 4'hF;
  // Pin order GPIO11,12,13,14,17,18,19,20 -> indicator index port*2+led
  localparam int IND_OF_PIN [NIND] = '{0, 1, 6, 7, 2, 3, 4, 5};
endpackage

// [hw/psi_blink.sv]
`timescale 1ns/1ps
`default_nettype none
module psi_blink
  import psi_pkg::*;
#(
  parameter logic [CNT_W-1:0] HALF_CYC = BLINK_HALF_CYC,
  parameter logic [CNT_W-1:0] STR_CYC = STRETCH_CYC
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic fast,
  input wire logic stretch_en,
  input wire logic [NPORT-1:0] act,
  input wire logic [NPORT-1:0] col,
  output logic phase,
  output logic [NPORT-1:0] act_s,
  output logic [NPORT-1:0] col_s
);
  typedef struct packed {
    logic [CNT_W-1:0] div;
    logic phase;
    logic [NPORT-1:0][CNT_W-1:0] act_cnt;
    logic [NPORT-1:0][CNT_W-1:0] col_cnt;
  } psi_blink_t;

  psi_blink_t st;
  psi_blink_t nxt;
  logic [CNT_W-1:0] lim;

  // Reload on an event, or clear when stretch is off; else count down to zero
  function automatic logic [CNT_W-1:0] stretch(input logic ev, input logic en,
                                               input logic [CNT_W-1:0] cnt);
    if (ev)
      return en ? STR_CYC : '0;
    else if (cnt != '0)
      return cnt - CNT_W'(1);
    return cnt;
  endfunction

  // Free running blink divider and per-port event stretchers
  always_comb
  begin
    nxt = st;
    lim = fast ? {1'b0, HALF_CYC[CNT_W-1:1]} : HALF_CYC;
    if (st.div >= lim - CNT_W'(1))
    begin
      nxt.div = '0;
      nxt.phase = !st.phase; // see R19
    end
    else
      nxt.div = st.div + CNT_W'(1);
    for (int p = 0; p < NPORT; p++)
    begin
      nxt.act_cnt[p] = stretch(act[p], stretch_en, st.act_cnt[p]); // see R13
      nxt.col_cnt[p] = stretch(col[p], stretch_en, st.col_cnt[p]);
      act_s[p] = act[p] | (st.act_cnt[p] != '0);
      col_s[p] = col[p] | (st.col_cnt[p] != '0);
    end
    phase = st.phase;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else if (clk_en)
      st <= nxt;
  end

  chk_blink_period: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && st.div == '0 && $past(st.div) != '0 |-> st.phase != $past(st.phase)) // see R19
    else $error("blink phase did not toggle at divider wrap");
endmodule // psi_blink
`default_nettype wire

// [hw/psi_fix_note_unused.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [bench/psi_lamp.sv]
`timescale 1ns/1ps
`default_nettype none
module psi_lamp
  import psi_pkg::*;
(
  input wire logic [NIND-1:0] pin_out,
  input wire logic [NIND-1:0] pin_oe,
  input wire logic [NIND-1:0] pol_strap,
  output logic [NIND-1:0] lamp_on
);
  // A released pin rests at its strap pull level, so only a driven level lights it
  always_comb
  begin
    for (int i = 0; i < NIND; i++)
    begin
      lamp_on[i] = (pin_oe[i] ? pin_out[i] : pol_strap[IND_OF_PIN[i]])
        != pol_strap[IND_OF_PIN[i]];
    end
  end
endmodule // psi_lamp
`default_nettype wire

// [bench/tb_port_status_indicator.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_port_status_indicator;
  import psi_pkg::*;
  typedef struct {int k; logic [31:0] a; logic [31:0] b; logic [31:0] c; string nm;} psi_note_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic suspend_hold = 1'b0;
  logic style = 1'b1;
  logic [7:0] pstrap = 8'h0;
  logic [3:0] lnk = 4'h0, fdx = 4'h0, act = 4'h0, col = 4'h0, flt = 4'h0;
  logic [7:0] spd = 8'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [7:0] pout, poe, lamp;
  psi_note_t q[$];
  int miscompares = 0;
  int checked = 0;
  logic rd_ph = 1'b0;
  logic [7:0] acc_or = 8'h0, acc_and = 8'hFF;
  logic [3:0] codes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA,
    4'hC, 4'hE, 4'hF};

  // Clock at 125 MHz
  always #4 hclk = ~hclk;

  psi_top #(.HALF_CYC(CNT_W'(8)), .STR_CYC(CNT_W'(4))) dut_u (
    .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .suspend_hold(suspend_hold),
    .indicator_style_strap(style), .indicator_polarity_strap(pstrap), .link_up(lnk),
    .link_speed(spd), .full_duplex(fdx), .activity(act), .collision(col), .pd_fault(flt),
    .led_pin_out(pout), .led_pin_oe(poe));

  psi_lamp lamp_u (.pin_out(pout), .pin_oe(poe), .pol_strap(pstrap), .lamp_on(lamp));

  task automatic end_of_test();
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Wait for hready at the next edges, bounded
  task automatic wait_rdy();
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        miscompares++;
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask

  // One single AHB transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input int k, input logic [31:0] x, input logic [31:0] y,
                    input logic [31:0] z, input string nm);
    q.push_back('{k, x, y, z, nm});
    xfer(1'b0, a, 32'h0);
  endtask

  // Sample lit state over more than a blink period: steady on, steady off or blinking
  task automatic win(input logic [7:0] on, input logic [7:0] bl, input logic [7:0] cm);
    repeat (11) rd(OFS_STATUS, 1, 32'h0, 32'h0, 32'h0, "");
    rd(OFS_STATUS, 2, {24'h0, on}, {24'h0, bl}, {24'h0, cm}, "");
  endtask

  task automatic do_reset(input logic s);
    @(posedge hclk);
    hresetn <= 1'b0;
    style <= s;
    pstrap <= 8'($urandom);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (10) @(posedge hclk);
  endtask

  // Expected enhanced state as {blink, on}
  function automatic logic [1:0] enh(input logic [3:0] c, input logic l, input logic [1:0] s,
                                     input logic f, input logic a, input logic k, input logic t);
    logic [2:0] m [7] = '{3'h7, 3'h4, 3'h2, 3'h1, 3'h6, 3'h5, 3'h3};
    if (c < 4'h7)
      return (l && m[c[2:0]][s]) ? {a, !a} : 2'h0;
    case (c)
      CODE_DUPLEX: return !l ? 2'h0 : (f ? 2'h1 : {k, 1'b0});
      CODE_COLL: return {k, 1'b0};
      CODE_ACT: return {a, 1'b0};
      CODE_FAULT: return {1'b0, t};
      CODE_ON: return 2'h1;
      default: return 2'h0;
    endcase
  endfunction

  // Monitor: each read data phase takes the oldest note
  always @(posedge hclk)
  begin
    psi_note_t n;
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    if (rd_ph && hreadyout === 1'b1 && q.size() > 0)
    begin
      n = q.pop_front();
      if (n.k == 0)
        cmp(n.nm, n.a & n.b, hrdata & n.b);
      else if (n.k == 3)
        cmp(n.nm, n.a & n.b, {24'h0, lamp} & n.b);
      else
      begin
        acc_or = acc_or | hrdata[7:0];
        acc_and = acc_and & hrdata[7:0];
        if (n.k == 2)
        begin
          cmp("lit steady", n.a & n.c, {24'h0, acc_and} & n.c);
          cmp("lit seen", (n.a | n.b) & n.c, {24'h0, acc_or} & n.c);
          acc_or = 8'h0;
          acc_and = 8'hFF;
        end
      end
    end
  end

  // Watchdog
  initial
  begin
    repeat (100000) @(posedge hclk);
    miscompares++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    logic l, f, a, k, t;
    logic [1:0] s, e1, e2;
    logic [3:0] ca, cb;
    void'($urandom(32'h39578BA5));
    do_reset(1'b1);
    rd(OFS_POL, 0, {24'h0, ~pstrap}, 32'hFF, 32'h0, "polarity");
    rd(OFS_STATUS, 0, 32'h600, 32'h700, 32'h0, "strap status");
    rd(OFS_BEHAV, 0, 32'h1, 32'h3, 32'h0, "behaviour");
    rd(OFS_CTRL1 + PORT_STRIDE, 0, 32'h40, 32'h40, 32'h0, "legacy bit");
    rd(8'h80, 0, 32'h0, 32'hFFFFFFFF, 32'h0, "unmapped");
    // Individual mode
    @(posedge hclk);
    lnk <= 4'hF;
    spd <= 8'($urandom) & 8'h55;
    win(8'hAA, 8'h00, 8'hFF);
    @(posedge hclk);
    act <= 4'h1;
    lnk <= 4'hD;
    win(8'hA2, 8'h01, 8'hFF);
    wr(OFS_BASIC + 8'h20, 32'h400);
    wr(OFS_BASIC + 8'h30, 32'h800);
    win(8'h02, 8'h01, 8'hFF);
    wr(OFS_BASIC + 8'h20, 32'h0);
    wr(OFS_BASIC + 8'h30, 32'h0);
    @(posedge hclk);
    suspend_hold <= 1'b1;
    repeat (6) @(posedge hclk);
    win(8'h00, 8'h00, 8'hFF);
    rd(OFS_STATUS, 0, 32'h100, 32'h100, 32'h0, "suspend");
    @(posedge hclk);
    suspend_hold <= 1'b0;
    repeat (6) @(posedge hclk);
    win(8'hA2, 8'h01, 8'hFF);
    // Pins through the lamp model
    @(posedge hclk);
    act <= 4'h0;
    repeat (8) @(posedge hclk);
    rd(OFS_STATUS, 3, 32'h0, 32'h3, 32'h0, "lamp");
    wr(OFS_PINCFG, 32'hF7);
    rd(OFS_STATUS, 3, 32'h2, 32'h3, 32'h0, "lamp");
    @(posedge hclk);
    lnk <= 4'hC;
    repeat (3) @(posedge hclk);
    rd(OFS_STATUS, 3, 32'h0, 32'h3, 32'h0, "lamp");
    // Tri-colour mode
    do_reset(1'b0);
    rd(OFS_STATUS, 0, 32'h400, 32'h700, 32'h0, "style");
    @(posedge hclk);
    lnk <= 4'h7;
    spd <= 8'h06;
    win(8'h36, 8'h00, 8'hFF);
    @(posedge hclk);
    act <= 4'h2;
    win(8'h32, 8'h04, 8'hFF);
    // Enhanced mode on port 0, every defined code
    wr(OFS_CTRL1, 32'h0);
    for (int i = 0; i < 13; i++)
    begin
      ca = codes[i];
      cb = codes[(i + 5) % 13];
      {l, f, a, k, t} = 5'($urandom);
      s = 2'($urandom % 3);
      @(posedge hclk);
      lnk[0] <= l;
      spd[1:0] <= s;
      fdx[0] <= f;
      act[0] <= a;
      col[0] <= k;
      flt[0] <= t;
      wr(OFS_CTRL2, {24'h0, cb, ca});
      repeat (10) @(posedge hclk);
      e1 = enh(ca, l, s, f, a, k, t);
      e2 = enh(cb, l, s, f, a, k, t);
      win({6'h0, e2[0], e1[0]}, {6'h0, e2[1], e1[1]}, 8'h03);
    end
    // Fast blink with stretch off, both indicators on the activity code
    wr(OFS_BEHAV, 32'h2);
    rd(OFS_BEHAV, 0, 32'h2, 32'h3, 32'h0, "behaviour");
    @(posedge hclk);
    act[0] <= 1'b1;
    wr(OFS_CTRL2, 32'hAA);
    win(8'h00, 8'h03, 8'h03);
    wr(OFS_CTRL2, 32'hFF);
    win(8'h03, 8'h00, 8'h03);
    wr(OFS_BASIC, 32'h400);
    win(8'h00, 8'h00, 8'h03);
    end_of_test();
  end
endmodule // tb_port_status_indicator
`default_nettype wire
